// [core/term_cfg_defs.svh]
`ifndef TERM_CFG_DEFS_SVH
`define TERM_CFG_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REG_ADDR_W 4
`define ROLE_CFG_OFS 4'h0
`define FRAME_TIME_OFS 4'h1
`define EXT_CFG_OFS 4'h2
`define SEQ_CTRL_OFS 4'h3

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ROLE_PRIMARY_BIT 15
`define ROLE_SECONDARY_BIT 14
`define MEM_PTR_BIT 13
`define MONITOR_EN_BIT 12
`define BUS_CTRL_ACC_N_BIT 11
`define BUSY_N_BIT 10
`define SVC_REQ_N_BIT 9
`define SUBSYS_N_BIT 8
`define FRAME_REPEAT_BIT 8
`define INT_TRIG_BIT 6
`define GAP_SEL_BIT 5
`define RETRY_EN_BIT 4
`define DOUBLE_RETRY_BIT 3
`define CTRL_ACTIVE_BIT 2
`define FRAME_IP_BIT 1
`define MSG_IP_BIT 0
`define ENHANCED_BIT 15
`define ALT_STATUS_BIT 5
`define START_BIT 0
`define STOP_BIT 1
`define ROLE_CFG_RST 16'h8000
`define FRAME_TIME_RST 16'h0000
`define EXT_CFG_RST 16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define NS_PER_US 1000
`define FRAME_STEP_US 100
`define DEFAULT_GAP_US 10
`define MIN_GAP_US 10

`endif

// [core/term_cfg_pkg.sv]
package term_cfg_pkg;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_MSG = 3'b001,
      SEQ_GAP = 3'b011,
      SEQ_FRAME_WAIT = 3'b010
   } seq_state_t;

   typedef struct packed {
      logic start;
      logic is_retry;
   } msg_req_t;

   typedef struct packed {
      logic busy;
      logic service_request;
      logic subsystem_flag;
      logic bus_control_accept;
      logic ignore_commands;
   } rt_status_t;

endpackage : term_cfg_pkg

// [core/terminal_config_control.sv]
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "term_cfg_defs.svh"

module terminal_config_control
#(
   parameter int FRAME_STEP_CYCLES = `FRAME_STEP_US * `NS_PER_US / `CLK_PERIOD_NS,
   parameter int MSG_COUNT_W = 8
)
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Host register port
   input wire logic [`REG_ADDR_W-1:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   // Message engine
   input wire logic [MSG_COUNT_W-1:0] MSG_COUNT,
   input wire logic [15:0] MSG_GAP_US,
   input wire logic MSG_RETRY_REQ,
   input wire logic MSG_DONE,
   input wire logic MSG_ERROR,
   input wire logic FRAME_ABORT,
   output term_cfg_pkg::msg_req_t MSG_REQ,
   // Terminal side
   input wire logic DYN_BUS_CTRL_CMD,
   output term_cfg_pkg::rt_status_t RT_STATUS,
   output logic MONITOR_EN,
   output logic RT_MONITOR_COMBINED,
   output logic MEM_PTR_SEL,
   output logic CTRL_ROLE
);

   // ----------------------------------------------------------------------
   // Time bases
   // ----------------------------------------------------------------------
   localparam int US_CYCLES = `NS_PER_US / `CLK_PERIOD_NS;

   logic [15:0] role_cfg_r;
   logic [15:0] frame_time_r;
   logic [15:0] ext_cfg_r;
   term_cfg_pkg::seq_state_t state_r;
   logic [MSG_COUNT_W-1:0] msg_idx_r;
   logic [1:0] tries_r;
   logic [15:0] us_pre_r;
   logic [15:0] gap_cnt_r;
   logic [15:0] gap_target;
   logic [31:0] step_pre_r;
   logic [15:0] frame_cnt_r;
   logic frame_expired;
   logic ctrl_mode;
   logic rt_mode;
   logic start_req;
   logic stop_req;
   logic may_retry;
   logic last_msg;
   logic repeat_frame;
   logic ctrl_active;
   logic frame_ip;
   logic msg_ip;
   logic [15:0] role_rd;

   // Role decoding selects which meaning each stored bit carries.
   assign ctrl_mode = ~role_cfg_r[`ROLE_PRIMARY_BIT];
   assign rt_mode = role_cfg_r[`ROLE_PRIMARY_BIT] & ~role_cfg_r[`ROLE_SECONDARY_BIT];
   assign start_req = WR && ADDR == `SEQ_CTRL_OFS && WDATA[`START_BIT] && ctrl_mode;
   assign stop_req = (WR && ADDR == `SEQ_CTRL_OFS && WDATA[`STOP_BIT]) || FRAME_ABORT ||
      !ctrl_mode;

   // ----------------------------------------------------------------------
   // Host registers
   // ----------------------------------------------------------------------
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         role_cfg_r <= `ROLE_CFG_RST;
         frame_time_r <= `FRAME_TIME_RST;
         ext_cfg_r <= `EXT_CFG_RST;
      end
      else if (WR)
      begin
         // The live flag positions are never stored.
         if (ADDR == `ROLE_CFG_OFS)
            role_cfg_r <= {WDATA[15:3], 3'b000};
         else if (ADDR == `FRAME_TIME_OFS)
            frame_time_r <= WDATA;
         else if (ADDR == `EXT_CFG_OFS)
            ext_cfg_r <= WDATA;
      end
   end

   always_comb
   begin
      role_rd = role_cfg_r;
      if (ctrl_mode)
      begin
         role_rd[`CTRL_ACTIVE_BIT] = ctrl_active;
         role_rd[`FRAME_IP_BIT] = frame_ip;
         role_rd[`MSG_IP_BIT] = msg_ip;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (RST || !RD)
         RDATA <= 16'h0000;
      else if (ADDR == `ROLE_CFG_OFS)
         RDATA <= role_rd;
      else if (ADDR == `FRAME_TIME_OFS)
         RDATA <= frame_time_r;
      else if (ADDR == `EXT_CFG_OFS)
         RDATA <= ext_cfg_r;
      else if (ADDR == `SEQ_CTRL_OFS)
         RDATA <= {13'h0000, state_r};
      else
         RDATA <= 16'h0000;
   end

   // ----------------------------------------------------------------------
   // Controller sequencer
   // ----------------------------------------------------------------------
   assign may_retry = role_cfg_r[`RETRY_EN_BIT] && MSG_RETRY_REQ &&
      (tries_r == 2'd0 || (tries_r == 2'd1 && role_cfg_r[`DOUBLE_RETRY_BIT]));
   assign last_msg = msg_idx_r + 1'b1 >= MSG_COUNT;
   // A repeating frame needs a fixed period; without it one frame runs.
   assign repeat_frame = role_cfg_r[`FRAME_REPEAT_BIT] &&
      role_cfg_r[`INT_TRIG_BIT];
   assign gap_target = !role_cfg_r[`GAP_SEL_BIT] ? 16'(`DEFAULT_GAP_US) :
      (MSG_GAP_US < 16'(`MIN_GAP_US) ? 16'(`MIN_GAP_US) : MSG_GAP_US);

   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         state_r <= term_cfg_pkg::SEQ_IDLE;
         msg_idx_r <= '0;
         tries_r <= 2'd0;
      end
      else if (stop_req)
      begin
         state_r <= term_cfg_pkg::SEQ_IDLE;
         tries_r <= 2'd0;
      end
      else
      begin
         case (state_r)
            term_cfg_pkg::SEQ_IDLE:
            begin
               if (start_req && MSG_COUNT != '0)
               begin
                  state_r <= term_cfg_pkg::SEQ_MSG;
                  msg_idx_r <= '0;
                  tries_r <= 2'd0;
               end
            end
            term_cfg_pkg::SEQ_MSG:
            begin
               if (MSG_DONE)
               begin
                  if (MSG_ERROR && may_retry)
                  begin
                     tries_r <= tries_r + 2'd1;
                  end
                  else
                  begin
                     tries_r <= 2'd0;
                     state_r <= term_cfg_pkg::SEQ_GAP;
                  end
               end
            end
            term_cfg_pkg::SEQ_GAP:
            begin
               if (gap_cnt_r >= gap_target)
               begin
                  if (!last_msg)
                  begin
                     msg_idx_r <= msg_idx_r + 1'b1;
                     state_r <= term_cfg_pkg::SEQ_MSG;
                  end
                  else if (repeat_frame)
                     state_r <= term_cfg_pkg::SEQ_FRAME_WAIT;
                  else
                     state_r <= term_cfg_pkg::SEQ_IDLE;
               end
            end
            term_cfg_pkg::SEQ_FRAME_WAIT:
            begin
               if (!repeat_frame)
               begin
                  state_r <= term_cfg_pkg::SEQ_IDLE;
               end
               else if (frame_expired)
               begin
                  msg_idx_r <= '0;
                  state_r <= term_cfg_pkg::SEQ_MSG;
               end
            end
            default:
               state_r <= term_cfg_pkg::SEQ_IDLE;
         endcase
      end
   end

   // Gap timer counts whole microseconds from the end of a message.
   always_ff @(posedge MCLK)
   begin
      if (RST || state_r != term_cfg_pkg::SEQ_GAP)
      begin
         us_pre_r <= 16'h0000;
         gap_cnt_r <= 16'h0000;
      end
      else if (us_pre_r == 16'(US_CYCLES - 1))
      begin
         us_pre_r <= 16'h0000;
         if (gap_cnt_r != 16'hFFFF)
         begin
            gap_cnt_r <= gap_cnt_r + 16'h0001;
         end
      end
      else
      begin
         us_pre_r <= us_pre_r + 16'h0001;
      end
   end

   // Frame period is measured from each frame start, so gaps and retries
   // inside a frame do not stretch it.
   assign frame_expired = frame_cnt_r >= frame_time_r;

   always_ff @(posedge MCLK)
   begin
      if (RST || state_r == term_cfg_pkg::SEQ_IDLE ||
          (state_r == term_cfg_pkg::SEQ_FRAME_WAIT && frame_expired))
      begin
         step_pre_r <= 32'h0000_0000;
         frame_cnt_r <= 16'h0000;
      end
      else if (step_pre_r == 32'(FRAME_STEP_CYCLES - 1))
      begin
         step_pre_r <= 32'h0000_0000;
         if (frame_cnt_r != 16'hFFFF)
         begin
            frame_cnt_r <= frame_cnt_r + 16'h0001;
         end
      end
      else
      begin
         step_pre_r <= step_pre_r + 32'h0000_0001;
      end
   end

   assign ctrl_active = state_r != term_cfg_pkg::SEQ_IDLE;
   assign frame_ip = state_r == term_cfg_pkg::SEQ_MSG ||
      (state_r == term_cfg_pkg::SEQ_GAP && !last_msg);
   assign msg_ip = state_r == term_cfg_pkg::SEQ_MSG;

   // Start pulse for each attempt, registered on the same edge as the sequencer commits.
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         MSG_REQ <= '0;
      end
      else
      begin
         MSG_REQ.start <= !stop_req && ((state_r == term_cfg_pkg::SEQ_IDLE && start_req &&
            MSG_COUNT != '0) || (state_r == term_cfg_pkg::SEQ_MSG && MSG_DONE && MSG_ERROR &&
            may_retry) || (state_r == term_cfg_pkg::SEQ_GAP && gap_cnt_r >= gap_target &&
            !last_msg) || (state_r == term_cfg_pkg::SEQ_FRAME_WAIT && repeat_frame &&
            frame_expired));
         MSG_REQ.is_retry <= state_r == term_cfg_pkg::SEQ_MSG && MSG_DONE && MSG_ERROR &&
            may_retry;
      end
   end

   // ----------------------------------------------------------------------
   // Terminal status and options
   // ----------------------------------------------------------------------
   // The active-low layout only holds without the alternate status word.
   logic rt_plain;
   assign rt_plain = rt_mode && !ext_cfg_r[`ALT_STATUS_BIT];

   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         RT_STATUS <= '0;
         MONITOR_EN <= 1'b0;
         RT_MONITOR_COMBINED <= 1'b0;
         MEM_PTR_SEL <= 1'b0;
         CTRL_ROLE <= 1'b0;
      end
      else
      begin
         RT_STATUS.bus_control_accept <= rt_plain && DYN_BUS_CTRL_CMD &&
            !role_cfg_r[`BUS_CTRL_ACC_N_BIT];
         RT_STATUS.busy <= rt_plain && !role_cfg_r[`BUSY_N_BIT];
         RT_STATUS.ignore_commands <= rt_plain && !role_cfg_r[`BUSY_N_BIT];
         RT_STATUS.service_request <= rt_plain && !role_cfg_r[`SVC_REQ_N_BIT];
         RT_STATUS.subsystem_flag <= rt_plain && !role_cfg_r[`SUBSYS_N_BIT];
         MONITOR_EN <= role_cfg_r[`MONITOR_EN_BIT];
         RT_MONITOR_COMBINED <= rt_mode && role_cfg_r[`MONITOR_EN_BIT];
         MEM_PTR_SEL <= role_cfg_r[`MEM_PTR_BIT];
         CTRL_ROLE <= ctrl_mode;
      end
   end

endmodule : terminal_config_control

`default_nettype wire

// [verif/terminal_config_control_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module terminal_config_control_properties (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Host port
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   // Outputs
   input wire term_cfg_pkg::msg_req_t MSG_REQ,
   input wire term_cfg_pkg::rt_status_t RT_STATUS,
   input wire logic MONITOR_EN,
   input wire logic RT_MONITOR_COMBINED,
   input wire logic MEM_PTR_SEL,
   input wire logic CTRL_ROLE
);
   logic alt_r;
   logic rw;
   logic tw;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   // Status outputs only follow the role register while alternate status is off.
   always_ff @(posedge MCLK)
      if (RST)
         alt_r <= 1'b0;
      else if (WR && ADDR == 4'h2)
         alt_r <= WDATA[5];
   assign rw = WR && ADDR == 4'h0;
   assign tw = rw && WDATA[15] && !WDATA[14] && !alt_r;
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
      else $error("read data outside read cycle");
   retry_start_a: assert property (MSG_REQ.is_retry |-> MSG_REQ.start)
      else $error("retry mark without start");
   role_sel_a: assert property (rw |-> ##2 CTRL_ROLE == !$past(WDATA[15], 2))
      else $error("role output wrong");
   mem_ptr_a: assert property (rw |-> ##2 MEM_PTR_SEL == $past(WDATA[13], 2))
      else $error("pointer output wrong");
   monitor_en_a: assert property (rw |-> ##2 MONITOR_EN == $past(WDATA[12], 2))
      else $error("monitor output wrong");
   combined_mode_a: assert property (rw && !WDATA[14] |-> ##2
      RT_MONITOR_COMBINED == ($past(WDATA[15], 2) && $past(WDATA[12], 2)))
      else $error("combined mode wrong");
   service_req_a: assert property (tw |-> ##2
      RT_STATUS.service_request == !$past(WDATA[9], 2))
      else $error("service request wrong");
   busy_status_a: assert property (tw |-> ##2 RT_STATUS.busy == !$past(WDATA[10], 2)
      && RT_STATUS.ignore_commands == !$past(WDATA[10], 2))
      else $error("busy status wrong");
   subsys_flag_a: assert property (tw |-> ##2
      RT_STATUS.subsystem_flag == !$past(WDATA[8], 2))
      else $error("subsystem flag wrong");
endmodule : terminal_config_control_properties
bind terminal_config_control terminal_config_control_properties chk (.MCLK(MCLK), .RST(RST),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MSG_REQ(MSG_REQ),
   .RT_STATUS(RT_STATUS), .MONITOR_EN(MONITOR_EN), .RT_MONITOR_COMBINED(RT_MONITOR_COMBINED),
   .MEM_PTR_SEL(MEM_PTR_SEL), .CTRL_ROLE(CTRL_ROLE));
`default_nettype wire

// [verif/msg_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
module msg_engine_model #(parameter int LAT = 20) (
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic [1:0] fails,
   // Message handshake
   input wire logic start,
   output logic done,
   output logic error
);
   int cnt_r;
   int att_r;
   // Error means nothing without done, so it toggles then to expose stale sampling.
   always_ff @(posedge clk)
   begin
      done <= cnt_r == 1;
      error <= (cnt_r == 1) ? att_r < fails : !error;
      if (rst || clr)
      begin
         cnt_r <= 0;
         att_r <= 0;
         error <= 1'b0;
      end
      else if (start)
         cnt_r <= LAT;
      else if (cnt_r > 0)
      begin
         cnt_r <= cnt_r - 1;
         if (cnt_r == 1)
            att_r <= att_r + 1;
      end
   end
endmodule : msg_engine_model
`default_nettype wire

// [verif/terminal_config_control_test.sv]
`timescale 1ns/10ps
`default_nettype none
module terminal_config_control_test;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic [3:0] ADDR = 4'h0;
   logic [15:0] WDATA = 16'h0000;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [15:0] RDATA;
   logic [7:0] MSG_COUNT = 8'h01;
   logic [15:0] MSG_GAP_US = 16'h0000;
   logic MSG_RETRY_REQ = 1'b0;
   logic MSG_DONE;
   logic MSG_ERROR;
   logic FRAME_ABORT = 1'b0;
   logic DYN_BUS_CTRL_CMD = 1'b0;
   term_cfg_pkg::msg_req_t MSG_REQ;
   term_cfg_pkg::rt_status_t RT_STATUS;
   logic MONITOR_EN;
   logic RT_MONITOR_COMBINED;
   logic MEM_PTR_SEL;
   logic CTRL_ROLE;
   logic clr = 1'b0;
   logic [1:0] fails = 2'h0;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int starts = 0;
   int retries = 0;
   int t_done = 0;
   int t_start = 0;
   int gap = 0;
   int period = 0;
   // A short frame step keeps the repeat period within a few thousand cycles.
   terminal_config_control #(.FRAME_STEP_CYCLES(10)) dut (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MSG_COUNT(MSG_COUNT),
      .MSG_GAP_US(MSG_GAP_US), .MSG_RETRY_REQ(MSG_RETRY_REQ), .MSG_DONE(MSG_DONE),
      .MSG_ERROR(MSG_ERROR), .FRAME_ABORT(FRAME_ABORT), .MSG_REQ(MSG_REQ),
      .DYN_BUS_CTRL_CMD(DYN_BUS_CTRL_CMD), .RT_STATUS(RT_STATUS), .MONITOR_EN(MONITOR_EN),
      .RT_MONITOR_COMBINED(RT_MONITOR_COMBINED), .MEM_PTR_SEL(MEM_PTR_SEL),
      .CTRL_ROLE(CTRL_ROLE));
   msg_engine_model eng (.clk(MCLK), .rst(RST), .clr(clr), .fails(fails),
      .start(MSG_REQ.start), .done(MSG_DONE), .error(MSG_ERROR));
   initial forever #4 MCLK = ~MCLK;
   always @(posedge MCLK)
   begin
      cyc <= cyc + 1;
      if (MSG_DONE)
         t_done <= cyc;
      if (MSG_REQ.start)
      begin
         starts <= starts + 1;
         retries <= retries + int'(MSG_REQ.is_retry);
         gap <= cyc - t_done;
         period <= cyc - t_start;
         t_start <= cyc;
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge MCLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge MCLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask : rd
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input string what);
      logic [15:0] d;
      rd(a, d);
      check(what, d, exp);
   endtask : rdc
   task automatic upto(input int n);
      for (int i = 0; i < 20000 && starts < n; i++)
         @(posedge MCLK);
      check("start count", 16'(starts >= n), 16'h0001);
   endtask : upto
   task automatic idle;
      logic [15:0] d;
      d = 16'hFFFF;
      for (int i = 0; i < 400 && d !== 16'h0000; i++)
      begin
         repeat (20) @(posedge MCLK);
         rd(4'h3, d);
      end
      check("sequencer idle", d, 16'h0000);
   endtask : idle
   task automatic dyn(input logic [15:0] exp, input string what);
      @(posedge MCLK);
      DYN_BUS_CTRL_CMD <= 1'b1;
      repeat (2) @(posedge MCLK);
      #1 check(what, RT_STATUS, exp);
      @(posedge MCLK);
      DYN_BUS_CTRL_CMD <= 1'b0;
   endtask : dyn
   task automatic run(input logic [15:0] cfg, input logic [7:0] cnt, input logic [15:0] us,
      input logic rq, output int n);
      int s0;
      @(posedge MCLK);
      MSG_COUNT <= cnt;
      MSG_GAP_US <= us;
      MSG_RETRY_REQ <= rq;
      clr <= 1'b1;
      wr(4'h0, cfg);
      clr <= 1'b0;
      s0 = starts;
      wr(4'h3, 16'h0001);
      idle;
      n = starts - s0;
   endtask : run
   task automatic t_reset;
      rdc(4'h0, 16'h8000, "role reset");
      rdc(4'hF, 16'h0000, "unmapped");
      check("reset status", RT_STATUS, 16'h001D);
      check("monitor", MONITOR_EN, 16'h0000);
      check("ctrl role", CTRL_ROLE, 16'h0000);
      $display("reset test done");
   endtask : t_reset
   task automatic t_term;
      wr(4'h2, 16'h8000);
      wr(4'h0, 16'hB800);
      dyn(16'h001D, "busy status");
      check("mem ptr", MEM_PTR_SEL, 16'h0001);
      check("combined", RT_MONITOR_COMBINED, 16'h0001);
      wr(4'h2, 16'h8020);
      dyn(16'h0000, "alt status");
      wr(4'h2, 16'h8000);
      wr(4'h0, 16'h8700);
      dyn(16'h0002, "ready status");
      check("combined", RT_MONITOR_COMBINED, 16'h0000);
      $display("terminal test done");
   endtask : t_term
   task automatic t_single;
      int s0;
      @(posedge MCLK);
      MSG_COUNT <= 8'h02;
      wr(4'h0, 16'h0007);
      s0 = starts;
      wr(4'h3, 16'h0001);
      rdc(4'h0, 16'h0007, "msg flags");
      repeat (60) @(posedge MCLK);
      rdc(4'h0, 16'h0006, "gap flags");
      upto(s0 + 2);
      repeat (60) @(posedge MCLK);
      rdc(4'h0, 16'h0004, "last gap");
      check("gap", 16'(gap >= 1250 && gap <= 1260), 16'h0001);
      idle;
      check("starts", 16'(starts - s0), 16'h0002);
      rdc(4'h0, 16'h0000, "idle flags");
      $display("single frame test done");
   endtask : t_single
   task automatic t_gap;
      int n;
      run(16'h0020, 8'h02, 16'h0014, 1'b0, n);
      check("long gap", 16'(gap >= 2500 && gap <= 2510), 16'h0001);
      run(16'h0020, 8'h02, 16'h0005, 1'b0, n);
      check("short gap", 16'(gap >= 1250 && gap <= 1260), 16'h0001);
      $display("gap test done");
   endtask : t_gap
   task automatic t_retry;
      logic [15:0] cfg[6] = '{16'h0010, 16'h0018, 16'h0018, 16'h0008, 16'h0100, 16'h0040};
      logic rq[6] = '{1, 1, 0, 1, 0, 0};
      int ex[6] = '{2, 3, 1, 1, 1, 1};
      int n;
      int r0;
      @(posedge MCLK);
      fails <= 2'h2;
      for (int i = 0; i < 6; i++)
      begin
         r0 = retries;
         run(cfg[i], 8'h01, 16'h0000, rq[i], n);
         check("attempts", 16'(n), 16'(ex[i]));
         check("retries", 16'(retries - r0), 16'(ex[i] - 1));
      end
      $display("retry test done");
   endtask : t_retry
   task automatic t_repeat;
      int s0;
      @(posedge MCLK);
      fails <= 2'h0;
      wr(4'h1, 16'h00C8);
      wr(4'h0, 16'h0140);
      s0 = starts;
      wr(4'h3, 16'h0001);
      upto(s0 + 3);
      check("period", 16'(period >= 1998 && period <= 2006), 16'h0001);
      @(posedge MCLK);
      FRAME_ABORT <= 1'b1;
      @(posedge MCLK);
      FRAME_ABORT <= 1'b0;
      idle;
      rdc(4'h0, 16'h0140, "after abort");
      $display("repeat test done");
   endtask : t_repeat
   task automatic conclude;
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   initial
   begin
      repeat (10) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      t_reset;
      t_term;
      t_single;
      t_gap;
      t_retry;
      t_repeat;
      conclude;
   end
   initial
   begin
      #(8 * 60000);
      bad_count++;
      conclude;
   end
endmodule : terminal_config_control_test
`default_nettype wire
